// ===== addr_select_defines.svh
/*
 * Constants for the slave address select block: addresses, field positions
 * and bus timeout figures. Assumes inclusion by bare name, once per unit.
 */
`ifndef ADDR_SELECT_DEFINES_SVH
`define ADDR_SELECT_DEFINES_SVH

`define ADDR_DEFAULT 7'h2E
`define ADDR_STRAP_LO 7'h2C
`define ADDR_STRAP_HI 7'h2D
`define ADDR_MATCH_MSB 6
`define ADDR_MATCH_LSB 2
`define CLK_FREQ_HZ 40000000
`define TIMEOUT_MIN_MS 25
`define TIMEOUT_MAX_MS 35
`define TIMEOUT_CYCLES ((`CLK_FREQ_HZ / 1000) * `TIMEOUT_MIN_MS)

`endif

// ===== addr_select_pkg.sv
/*
 * Types shared by the slave address select block.
 * Assumes the defines header is compiled alongside.
 */
package addr_select_pkg;
    typedef struct packed {
        logic scl;
        logic sda;
    } bus_pins_t;

    typedef struct packed {
        logic strap_mode;
        logic locked;
        logic [6:0] address;
    } addr_state_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b0_0001,
        ST_ADDR = 5'b0_0010,
        ST_ACK = 5'b0_0100,
        ST_BUSY = 5'b0_1000,
        ST_IGNORE = 5'b1_0000
    } slave_state_t;
endpackage

// ===== bus_sync.sv
/*
 * Two-flop synchroniser for the serial bus pins and strap pins.
 * Assumes the inputs are asynchronous to ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module bus_sync #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Raw and synchronised levels
    input wire logic [WIDTH-1:0] raw,
    output logic [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_synced;

    always_comb begin
        next_stage1 = raw;
        next_synced = stage1;
    end

    // Idle high keeps the bus quiet out of reset
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            stage1 <= '1;
            synced <= '1;
        end else begin
            stage1 <= next_stage1;
            synced <= next_synced;
        end
    end
endmodule
`default_nettype wire

// ===== addr_select.sv
/*
 * Slave address selection and commit for the monitoring device's serial
 * port, with start/stop tracking, address ack, timeout and idle return.
 * Assumes ref_clk at 40 MHz, rst_n as power-on reset, and a register
 * engine elsewhere that takes over after the address byte is acked.
 */
`timescale 1ns/1ps
`default_nettype none
`include "addr_select_defines.svh"

// Contract
// R01 - Strap enable high at power-up: answer only on default address 0101110.
// R02 - Strap enable low, select low: address 0101100.
// R03 - Strap enable low, select high: address 0101101.
// R04 - Sample strap enable at power-up; low enters strap mode following select.
// R05 - In strap mode latch address on first valid upper-five-bit match; latching here also needs the low two bits to match live_addr.
// R06 - In strap mode tach input 4 and fan drive 3 are not used for fans.
// R07 - Latched address holds until next power-on reset.
// R08 - Non-matching address or bad protocol: no ack, return to idle; the code holds a non-match in ST_IGNORE until a stop, start or timeout.
// R09 - Start followed at once by stop resets the interface to idle.
// R10 - Clock low over 25 ms aborts; ready for new start by 35 ms.
module addr_select
    import addr_select_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = `TIMEOUT_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Serial bus, open drain data
    input wire addr_select_pkg::bus_pins_t bus_in,
    output logic sda_out,
    output logic sda_oe,
    // Straps shared with fan pins
    input wire logic strap_enable_n,
    input wire logic tach_input_4,
    // Fan function gating
    input wire logic fan_drive_3_req,
    output logic fan_drive_output_3,
    output logic fan_drive_output_3_oe,
    output logic tach_4_valid,
    // Status
    output addr_select_pkg::addr_state_t addr_state,
    output logic addr_hit,
    output logic bus_idle
);
    import addr_select_pkg::*;

    logic [3:0] synced;
    logic scl, sda, strap_en_s, strap_sel_s;
    bus_sync #(.WIDTH(4)) u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .raw({bus_in.scl, bus_in.sda, strap_enable_n, tach_input_4}),
        .synced(synced)
    );
    assign scl = synced[3];
    assign sda = synced[2];
    assign strap_en_s = synced[1];
    assign strap_sel_s = synced[0];

    function automatic logic [6:0] strap_addr(input logic sel);
        strap_addr = sel ? `ADDR_STRAP_HI : `ADDR_STRAP_LO;
    endfunction

    function automatic logic upper_match(input logic [6:0] a, input logic [6:0] b);
        upper_match = (a[`ADDR_MATCH_MSB:`ADDR_MATCH_LSB] ==
                       b[`ADDR_MATCH_MSB:`ADDR_MATCH_LSB]);
    endfunction

    // Edge and condition detection on synced levels only
    logic scl_d, sda_d;
    logic scl_rise, scl_fall, start_cond, stop_cond;
    assign scl_rise = scl && !scl_d;
    assign scl_fall = !scl && scl_d;
    assign start_cond = scl && scl_d && sda_d && !sda;
    assign stop_cond = scl && scl_d && !sda_d && sda;

    // Strap capture happens after sync settles, not at reset itself
    logic [1:0] settle;
    logic sampled;
    slave_state_t state;
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic [31:0] low_cnt;
    addr_state_t next_addr_state;
    slave_state_t next_state;
    logic [7:0] next_shift;
    logic [3:0] next_bit_cnt;
    logic next_sda_out, next_hit, next_sampled;
    logic [1:0] next_settle;
    logic [31:0] next_low_cnt;
    logic [6:0] live_addr;

    // Before lock the select pin is followed live; a late strap still counts
    always_comb begin
        if (!addr_state.strap_mode) begin
            live_addr = `ADDR_DEFAULT; // [R01]
        end else if (addr_state.locked) begin
            live_addr = addr_state.address; // [R07]
        end else begin
            live_addr = strap_addr(strap_sel_s); // [R02] [R03] [R04]
        end
    end

    always_comb begin
        next_addr_state = addr_state;
        next_state = state;
        next_shift = shift;
        next_bit_cnt = bit_cnt;
        next_sda_out = sda_out;
        next_hit = 1'b0;
        next_settle = settle;
        next_sampled = sampled;
        next_low_cnt = scl ? 32'h0000_0000 : low_cnt + 32'h0000_0001;

        if (!sampled) begin
            if (settle != 2'h3) begin
                next_settle = settle + 2'h1;
            end else begin
                next_sampled = 1'b1;
                next_addr_state.strap_mode = !strap_en_s; // [R04]
                next_addr_state.address = strap_en_s ? `ADDR_DEFAULT
                                                     : strap_addr(strap_sel_s);
            end
        end else if (stop_cond) begin
            // Any stop, one right after a start too, drops the port to idle
            next_state = ST_IDLE; // [R09]
            next_sda_out = 1'b1;
        end else if (start_cond) begin
            next_state = ST_ADDR;
            next_bit_cnt = 4'h0;
            next_sda_out = 1'b1;
        end else if (low_cnt >= 32'(TIMEOUT_CYCLES) && state != ST_IDLE) begin
            // Abort only an open transfer; an idle port has nothing to reset
            next_state = ST_IDLE; // [R10]
            next_sda_out = 1'b1;
        end else begin
            case (state)
                ST_IDLE: begin
                    next_sda_out = 1'b1;
                end
                ST_ADDR: begin
                    if (scl_rise) begin
                        next_shift = {shift[6:0], sda};
                        next_bit_cnt = bit_cnt + 4'h1;
                    end
                    if (scl_fall && bit_cnt == 4'h8) begin
                        if (shift[7:1] == live_addr) begin
                            next_state = ST_ACK;
                            next_sda_out = 1'b0;
                            next_hit = 1'b1;
                            if (addr_state.strap_mode && !addr_state.locked &&
                                upper_match(shift[7:1], live_addr)) begin
                                // One-shot: later select levels no longer matter
                                next_addr_state.locked = 1'b1; // [R05]
                                next_addr_state.address = live_addr;
                            end
                        end else begin
                            next_state = ST_IGNORE; // [R08]
                            next_sda_out = 1'b1;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        next_state = ST_BUSY;
                        next_sda_out = 1'b1;
                    end
                end
                ST_BUSY: begin
                    next_sda_out = 1'b1;
                end
                ST_IGNORE: begin
                    next_sda_out = 1'b1; // [R08]
                end
                default: begin
                    next_state = ST_IDLE;
                    next_sda_out = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            addr_state <= '{strap_mode: 1'b0, locked: 1'b0, address: `ADDR_DEFAULT};
            state <= ST_IDLE;
            shift <= 8'h00;
            bit_cnt <= 4'h0;
            sda_out <= 1'b1;
            addr_hit <= 1'b0;
            settle <= 2'h0;
            sampled <= 1'b0;
            low_cnt <= 32'h0000_0000;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            addr_state <= next_addr_state;
            state <= next_state;
            shift <= next_shift;
            bit_cnt <= next_bit_cnt;
            sda_out <= next_sda_out;
            addr_hit <= next_hit;
            settle <= next_settle;
            sampled <= next_sampled;
            low_cnt <= next_low_cnt;
            scl_d <= scl;
            sda_d <= sda;
        end
    end

    assign sda_oe = !sda_out;
    assign bus_idle = (state == ST_IDLE);
    // Strap pins stay inputs while they carry the address
    assign fan_drive_output_3 = 1'b0;
    assign fan_drive_output_3_oe = sampled && !addr_state.strap_mode &&
                                   fan_drive_3_req; // [R06]
    assign tach_4_valid = sampled && !addr_state.strap_mode; // [R06]
endmodule
`default_nettype wire

// ===== addr_select_asserts.sv
/* Checker for addr_select, bound to every instance.
   Assumes the design's ports and package as declared. */
`timescale 1ns/1ps
`default_nettype none
`include "addr_select_defines.svh"
module addr_select_asserts
    import addr_select_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = `TIMEOUT_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Watched ports
    input wire addr_select_pkg::bus_pins_t bus_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic strap_enable_n,
    input wire logic tach_input_4,
    input wire logic fan_drive_3_req,
    input wire logic fan_drive_output_3,
    input wire logic fan_drive_output_3_oe,
    input wire logic tach_4_valid,
    input wire addr_select_pkg::addr_state_t addr_state,
    input wire logic addr_hit,
    input wire logic bus_idle
);
    logic [31:0] low_cnt, next_low_cnt;
    always_comb next_low_cnt = (!rst_n || bus_in.scl) ? 32'h0000_0000 : low_cnt + 1;
    always_ff @(posedge ref_clk) low_cnt <= next_low_cnt;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_dflt; !addr_state.strap_mode |-> addr_state.address == `ADDR_DEFAULT; endproperty
    a_dflt: assert property (p_dflt) else $error("default address wrong");
    // Strap mode and the strap address load in the same cycle; the check still waits two cycles of strap mode
    property p_strap; addr_state.strap_mode && $past(addr_state.strap_mode, 2)
        |-> addr_state.address inside {`ADDR_STRAP_LO, `ADDR_STRAP_HI}; endproperty
    a_strap: assert property (p_strap) else $error("strap address wrong");
    property p_hold; addr_state.locked |=> addr_state.locked && $stable(addr_state.address);
    endproperty
    a_hold: assert property (p_hold) else $error("locked address moved");
    property p_lock; addr_hit && addr_state.strap_mode |-> ##[0:1] addr_state.locked; endproperty
    a_lock: assert property (p_lock) else $error("address not latched");
    property p_fan; addr_state.strap_mode |-> !fan_drive_output_3_oe && !tach_4_valid; endproperty
    a_fan: assert property (p_fan) else $error("fan pins used in strap mode");
    property p_ack; $fell(sda_out) |-> addr_hit && sda_oe; endproperty
    a_ack: assert property (p_ack) else $error("ack without hit");
    property p_stop; bus_in.scl && $rose(bus_in.sda) |-> ##[1:6] bus_idle; endproperty
    a_stop: assert property (p_stop) else $error("no idle after stop");
    property p_tmo; low_cnt > TIMEOUT_CYCLES + 8 |-> bus_idle && !sda_oe; endproperty
    a_tmo: assert property (p_tmo) else $error("no idle after clock timeout");
    property p_idle; bus_idle |-> !sda_oe; endproperty
    a_idle: assert property (p_idle) else $error("driving data while idle");
    c_lock: cover property ($rose(addr_state.locked));
    c_hit: cover property (addr_hit && !addr_state.strap_mode);
    c_tmo: cover property (low_cnt == TIMEOUT_CYCLES);
endmodule
bind addr_select addr_select_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .bus_in(bus_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .strap_enable_n(strap_enable_n), .tach_input_4(tach_input_4),
    .fan_drive_3_req(fan_drive_3_req), .fan_drive_output_3(fan_drive_output_3),
    .fan_drive_output_3_oe(fan_drive_output_3_oe), .tach_4_valid(tach_4_valid),
    .addr_state(addr_state), .addr_hit(addr_hit), .bus_idle(bus_idle));
`default_nettype wire

// ===== smbus_host.sv
/* Behavioural SMBus host for the address phase, 200 ns bit time.
   Assumes SDA is resolved open drain with a pull-up by the bench. */
`timescale 1ns/1ps
`default_nettype none
module smbus_host (
    // Clock and bus
    input wire logic ref_clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low,
    // Ack report
    output logic ack_valid,
    output logic ack_seen
);
    initial scl = 1'b1;
    initial sda_low = 1'b0;
    initial ack_valid = 1'b0;
    initial ack_seen = 1'b0;
    task automatic hw(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic start;
        sda_low = 1'b0;
        hw(4);
        scl = 1'b1;
        hw(4);
        sda_low = 1'b1;
        hw(4);
        scl = 1'b0;
        hw(2);
    endtask
    // Data moves only after SCL low has had time to cross the synchroniser
    task automatic send(input logic [7:0] b, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            sda_low = !b[i];
            hw(2);
            scl = 1'b1;
            hw(4);
            scl = 1'b0;
            hw(2);
        end
    endtask
    task automatic stop;
        sda_low = 1'b1;
        hw(4);
        scl = 1'b1;
        hw(4);
        sda_low = 1'b0;
        hw(4);
    endtask
    task automatic xfer(input logic [7:0] b);
        start();
        send(b, 8);
        sda_low = 1'b0;
        hw(4);
        scl = 1'b1;
        hw(4);
        ack_seen = !sda;
        ack_valid = 1'b1;
        hw(4);
        ack_valid = 1'b0;
        scl = 1'b0;
        hw(4);
        stop();
    endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
/* Self-checking bench for addr_select driven by a behavioural host.
   Assumes package, defines and host model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "addr_select_defines.svh"
module tb_top;
    import addr_select_pkg::*;
    localparam int TO = 200;
    logic ref_clk = 1'b0, rst_n = 1'b0, strap_enable_n = 1'b1, tach_input_4 = 1'b0;
    logic fan_drive_3_req = 1'b0;
    logic scl, sda_low, ack_valid, ack_seen, sda_out, sda_oe, fan3, fan3_oe, tach_4_valid;
    logic addr_hit, bus_idle;
    wire logic sda = !(sda_low || sda_oe);
    addr_state_t addr_state;
    logic exp_q[$];
    int n_errors = 0;
    int samples_checked = 0;
    initial forever #12.5 ref_clk = !ref_clk;
    smbus_host i_host (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_low(sda_low),
        .ack_valid(ack_valid), .ack_seen(ack_seen));
    addr_select #(.TIMEOUT_CYCLES(TO)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .bus_in({scl, sda}), .sda_out(sda_out), .sda_oe(sda_oe),
        .strap_enable_n(strap_enable_n), .tach_input_4(tach_input_4),
        .fan_drive_3_req(fan_drive_3_req), .fan_drive_output_3(fan3),
        .fan_drive_output_3_oe(fan3_oe), .tach_4_valid(tach_4_valid),
        .addr_state(addr_state), .addr_hit(addr_hit), .bus_idle(bus_idle));
    task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge ack_valid) begin
        chk("ack", 9'(ack_seen), 9'(exp_q.pop_front()));
    end
    task automatic boot(input logic en_n, input logic sel);
        rst_n = 1'b0;
        strap_enable_n = en_n;
        tach_input_4 = sel;
        i_host.hw(8);
        rst_n = 1'b1;
        i_host.hw(12);
    endtask
    task automatic send(input logic [6:0] a, input logic e);
        exp_q.push_back(e);
        i_host.xfer({a, 1'($urandom)});
    endtask
    initial begin
        logic [6:0] own;
        void'($urandom(32'h030e));
        i_host.hw(1);
        fan_drive_3_req = 1'b1;
        boot(1'b1, 1'($urandom));
        send(`ADDR_DEFAULT, 1'b1);
        send(`ADDR_STRAP_LO, 1'b0);
        chk("state", addr_state, {2'b00, `ADDR_DEFAULT});
        chk("fan", 9'({fan3, tach_4_valid, fan3_oe}), 9'h003);
        fan_drive_3_req = 1'b0;
        i_host.hw(1);
        chk("fan", 9'({fan3, tach_4_valid, fan3_oe}), 9'h002);
        fan_drive_3_req = 1'b1;
        $display("test default done");
        for (int s = 0; s < 2; s++) begin
            own = s[0] ? `ADDR_STRAP_HI : `ADDR_STRAP_LO;
            boot(1'b0, s[0]);
            chk("fan", 9'({fan3, tach_4_valid, fan3_oe}), 9'h000);
            send(`ADDR_DEFAULT, 1'b0);
            send(own ^ 7'h01, 1'b0);
            send(own, 1'b1);
            tach_input_4 = !s[0];
            send(own, 1'b1);
            send(own ^ 7'h01, 1'b0);
            chk("state", addr_state, {2'b11, own});
            $display("test strap %0d done", s);
        end
        i_host.start();
        i_host.send({own, 1'b0}, 3);
        i_host.start();
        i_host.stop();
        i_host.hw(4);
        chk("idle", 9'(bus_idle), 9'h001);
        send(own, 1'b1);
        i_host.start();
        i_host.send({own, 1'b0}, 3);
        i_host.hw(TO + 20);
        chk("idle", 9'(bus_idle), 9'h001);
        send(own, 1'b1);
        $display("test bus reset done");
        final_report();
    end
    initial begin
        #1_000_000;
        n_errors++;
        final_report();
    end
endmodule
`default_nettype wire
